// [hdl/lsm_axi_addr.sv]
// module: address phase generator for uncached load/store multiples
`timescale 1ns/1ps
module lsm_axi_addr
  import lsm_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // bus clock enable from the system
  input  wire logic      bus_clock_gate_enable,
  // request from the load/store unit
  input  wire logic      req_valid,
  input  wire lsm_req_t  req,
  output logic           req_ready,
  // read address channel
  output logic           arvalid,
  output lsm_addr_t      ar,
  input  wire logic      arready,
  // write address channel
  output logic           awvalid,
  output lsm_addr_t      aw,
  input  wire logic      awready
);

  ////////////////////////////////////////////////////////////////////////
  // access shaping
  function automatic lsm_addr_t shape(input logic [ADDR_W-1:0] a,
                                      input logic              store,
                                      input logic              odd,
                                      input logic              even_register_count,
                                      input logic              first_access_flag,
                                      input logic              last_access_flag);
    lsm_addr_t r;
    r.len   = LEN_SINGLE;
    r.burst = BURST_INCR;
    r.lock  = LOCK_NORMAL;
    r.addr  = {a[ADDR_W-1:3], LOW_DW};
    r.size  = SIZE_64;
    if (!odd) begin
      if (first_access_flag && last_access_flag && !even_register_count)
        r.size = SIZE_32;
    end else if (first_access_flag) begin
      r.size = SIZE_32;
      r.addr = store ? {a[ADDR_W-1:3], LOW_ODD_STORE}
                     : {a[ADDR_W-1:3], a[2:0] & LOW_WORD_MASK};
    end else if (last_access_flag && even_register_count) begin
      r.size = SIZE_32;
    end
    return r;
  endfunction : shape

  ////////////////////////////////////////////////////////////////////////
  // state
  lsm_state_t        state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [CNT_W-1:0]  left_reg, left_next;
  logic              store_reg, store_next;
  logic              odd_reg, odd_next;
  logic              even_reg, even_next;
  logic              first_reg, first_next;
  logic              ready_reg, ready_next;
  logic              arv_reg, arv_next;
  logic              awv_reg, awv_next;
  lsm_addr_t         chan_reg, chan_next;
  logic              last_now;
  logic [CNT_W-1:0]  words_now;
  logic              odd_first;
  logic              hand_now;

  ////////////////////////////////////////////////////////////////////////
  // step planning
  // last access: the rest fits in one access
  function automatic logic step_last(input logic [CNT_W-1:0] left,
                                     input logic             odd_first_in);
    logic l;
    l = 1'b0;
    if (left <= CNT_TWO) begin
      if (!odd_first_in || left == CNT_ONE) begin
        l = 1'b1;
      end
    end
    return l;
  endfunction : step_last

  // registers consumed: odd first takes one, a last access takes the rest, else a pair
  function automatic logic [CNT_W-1:0] step_words(input logic [CNT_W-1:0] left,
                                                  input logic             odd_first_in);
    logic [CNT_W-1:0] w;
    w = odd_first_in ? CNT_ONE : CNT_TWO;
    if (step_last(left, odd_first_in)) begin
      w = left;
    end
    return w;
  endfunction : step_words

  always_comb begin
    odd_first = odd_reg && first_reg;
    last_now  = step_last(left_reg, odd_first);
    words_now = step_words(left_reg, odd_first);
    hand_now  = (arv_reg && arready) || (awv_reg && awready);
  end

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    left_next  = left_reg;
    store_next = store_reg;
    odd_next   = odd_reg;
    even_next  = even_reg;
    first_next = first_reg;
    ready_next = ready_reg;
    arv_next   = arv_reg;
    awv_next   = awv_reg;
    chan_next  = chan_reg;
    if (bus_clock_gate_enable) begin
      case (state_reg)
        LSM_IDLE: begin
          ready_next = 1'b1;
          if (ready_reg && req_valid && req.regs != CNT_ZERO) begin
            addr_next  = req.base;
            left_next  = req.regs;
            store_next = req.is_store;
            odd_next   = req.base[2];
            even_next  = ~req.regs[0];
            first_next = 1'b1;
            ready_next = 1'b0;
            state_next = LSM_ISSUE;
          end
        end
        LSM_ISSUE: begin
          chan_next  = shape(addr_reg, store_reg, odd_reg, even_reg, first_reg, last_now);
          arv_next   = ~store_reg;
          awv_next   = store_reg;
          state_next = LSM_WAIT;
        end
        LSM_WAIT: begin
          if (hand_now) begin
            arv_next   = 1'b0;
            awv_next   = 1'b0;
            first_next = 1'b0;
            left_next  = left_reg - words_now;
            addr_next  = {addr_reg[ADDR_W-1:3], LOW_DW} + DW_STEP;
            state_next = last_now ? LSM_IDLE : LSM_ISSUE;
          end
        end
        default: state_next = LSM_IDLE;
      endcase
    end
  end

  // all state on the core clock rising edge, gated by the enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LSM_IDLE;
      addr_reg  <= '0;
      left_reg  <= '0;
      store_reg <= 1'b0;
      odd_reg   <= 1'b0;
      even_reg  <= 1'b0;
      first_reg <= 1'b0;
      ready_reg <= 1'b0;
      arv_reg   <= 1'b0;
      awv_reg   <= 1'b0;
      chan_reg  <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      left_reg  <= left_next;
      store_reg <= store_next;
      odd_reg   <= odd_next;
      even_reg  <= even_next;
      first_reg <= first_next;
      ready_reg <= ready_next;
      arv_reg   <= arv_next;
      awv_reg   <= awv_next;
      chan_reg  <= chan_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign req_ready = ready_reg;
  assign arvalid   = arv_reg;
  assign awvalid   = awv_reg;
  assign ar        = chan_reg;
  assign aw        = chan_reg;

endmodule : lsm_axi_addr

// [hdl/lsm_pkg.sv]
// package: constants and types for the multiple-access address generator
package lsm_pkg;

  localparam int          ADDR_W        = 32;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;
  localparam logic [4:0]  CNT_ONE       = 5'h01;
  localparam logic [4:0]  CNT_TWO       = 5'h02;
  localparam logic [2:0]  SIZE_32       = 3'h2;
  localparam logic [2:0]  SIZE_64       = 3'h3;
  localparam logic [3:0]  LEN_SINGLE    = 4'h0;
  localparam logic [1:0]  BURST_INCR    = 2'h1;
  localparam logic [1:0]  LOCK_NORMAL   = 2'h0;
  localparam logic [2:0]  LOW_DW        = 3'h0;
  localparam logic [2:0]  LOW_ODD_STORE = 3'h4;
  localparam logic [2:0]  LOW_WORD_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] DW_STEP = 32'h0000_0008;
  localparam int          EN_SYNC_DEPTH = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0]        len;
    logic [2:0]        size;
    logic [1:0]        burst;
    logic [1:0]        lock;
  } lsm_addr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [CNT_W-1:0]  regs;
    logic              is_store;
  } lsm_req_t;

  typedef enum logic [1:0] {
    LSM_IDLE  = 2'b00,
    LSM_ISSUE = 2'b01,
    LSM_WAIT  = 2'b10
  } lsm_state_t;

endpackage : lsm_pkg

// [bench/lsm_axi_addr_asserts.sv]
// checker: address channel properties
`timescale 1ns/1ps
module lsm_axi_addr_asserts
  import lsm_pkg::*;
(
  // watched ports
  input wire logic      clk,
  input wire logic      rst_n,
  input wire logic      bus_clock_gate_enable,
  input wire logic      req_valid,
  input wire lsm_req_t  req,
  input wire logic      req_ready,
  input wire logic      arvalid,
  input wire lsm_addr_t ar,
  input wire logic      arready,
  input wire logic      awvalid,
  input wire lsm_addr_t aw,
  input wire logic      awready
);
  wire e = bus_clock_gate_enable;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ar_form_a: assert property (arvalid |-> {ar.len, ar.burst, ar.lock} == {LEN_SINGLE, BURST_INCR, LOCK_NORMAL})
    else $error("ar form");
  aw_form_a: assert property (awvalid |-> {aw.len, aw.burst, aw.lock} == {LEN_SINGLE, BURST_INCR, LOCK_NORMAL})
    else $error("aw form");
  ar_dw_a: assert property (arvalid && ar.size == SIZE_64 |-> ar.addr[2:0] == LOW_DW) else $error("ar align");
  aw_dw_a: assert property (awvalid && aw.size == SIZE_64 |-> aw.addr[2:0] == LOW_DW) else $error("aw align");
  ar_hold_a: assert property (arvalid && !(e && arready) |=> arvalid && $stable(ar)) else $error("ar hold");
  gate_a: assert property (!e |=> $stable({arvalid, awvalid, req_ready})) else $error("gate");
  beat_end_a: assert property (e && arvalid && arready |=> !arvalid) else $error("one beat");
  take_a: assert property (e && req_valid && req_ready && req.regs != 0 |=> !req_ready) else $error("take");
endmodule : lsm_axi_addr_asserts
////////////////////////////////////////////////////////////////
bind lsm_axi_addr lsm_axi_addr_asserts u_chk (.*);

// [bench/lsm_axi_slave.sv]
// partner: address channel slave with optional stall
`timescale 1ns/1ps
module lsm_axi_slave (
  // clock, reset, mode
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic slow,
  // ready outputs
  output logic      arready,
  output logic      awready
);
  logic [2:0] cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_reg + 3'h1;
  end
  assign arready = !slow || cnt_reg == 3'h5;
  assign awready = arready;
endmodule : lsm_axi_slave

// [bench/axi_multiple_access_and_clock_gating_test.sv]
// testbench: multiple-access address generation scenarios
`timescale 1ns/1ps
module axi_multiple_access_and_clock_gating_test;
  import lsm_pkg::*;
  logic        clk = 0, rst_n = 0, en = 0, rv = 0, slow = 0, ar_rdy, aw_rdy, ready, arv, awv;
  lsm_req_t    rq = '0;
  lsm_addr_t   ar, aw;
  logic [35:0] q[$];
  int          failures = 0, total_checks = 0, div = 1, cnt = 0;
  lsm_axi_addr dut (.clk(clk), .rst_n(rst_n), .bus_clock_gate_enable(en), .req_valid(rv), .req(rq),
    .req_ready(ready), .arvalid(arv), .ar(ar), .arready(ar_rdy), .awvalid(awv), .aw(aw), .awready(aw_rdy));
  lsm_axi_slave u_slv (.clk(clk), .rst_n(rst_n), .slow(slow), .arready(ar_rdy), .awready(aw_rdy));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    en <= cnt == 0;
    cnt <= cnt + 1 >= div ? 0 : cnt + 1;
  end
  always @(negedge clk) begin
    if (en && arv && ar_rdy) q.push_back({1'b0, ar.addr, ar.size});
    if (en && awv && aw_rdy) q.push_back({1'b1, aw.addr, aw.size});
  end
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic [31:0] b, input logic [4:0] n, input logic s, input int num);
    int i;
    q = {};
    @(posedge clk);
    rv <= 1;
    rq <= '{b, n, s};
    @(negedge clk);
    for (i = 0; i < 99 && !(en && ready); i++) @(negedge clk);
    @(posedge clk) rv <= 0;
    @(negedge clk);
    for (i = 0; i < 200 && !ready; i++) @(negedge clk);
    chk(36'(q.size()), 36'(num));
  endtask : xfer
  task t_even_load;
    xfer(32'h100, 5'h3, 0, 2);
    chk(q[0], {1'b0, 32'h100, SIZE_64});
    chk(q[1], {1'b0, 32'h108, SIZE_64});
  endtask : t_even_load
  task t_odd_load;
    div = 3;
    @(posedge clk) slow <= 1;
    xfer(32'h104, 5'h4, 0, 3);
    chk(q[0], {1'b0, 32'h104, SIZE_32});
    chk(q[1], {1'b0, 32'h108, SIZE_64});
    chk(q[2], {1'b0, 32'h110, SIZE_32});
    xfer(32'h404, 5'h3, 0, 2);
    chk(q[0], {1'b0, 32'h404, SIZE_32});
    chk(q[1], {1'b0, 32'h408, SIZE_64});
  endtask : t_odd_load
  task t_odd_store;
    xfer(32'h204, 5'h3, 1, 2);
    chk(q[0], {1'b1, 32'h204, SIZE_32});
    chk(q[1], {1'b1, 32'h208, SIZE_64});
  endtask : t_odd_store
  task t_lone;
    xfer(32'h300, 5'h1, 1, 1);
    chk(q[0], {1'b1, 32'h300, SIZE_32});
    xfer(32'h300, 5'h0, 1, 0);
  endtask : t_lone
  task close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    t_even_load;
    t_odd_load;
    t_odd_store;
    t_lone;
    close_out;
  end
endmodule : axi_multiple_access_and_clock_gating_test
